// file: cdda_pkg.sv
/*
 * Constants, message tags and types for the colour interpolator stage.
 * Assumes a message stream of 9-bit tags and 32-bit data words.
 */
// Functional notes
// - Always compute red, green, blue and alpha
// - Visible step emits colour, then advances DDAs
// - Flat shading emits constant value, red low
// - Adder adds; subtracts only for negative correction
// - Values 9.15 fixed point, two guard bits
// - Guard band overflow simply wraps around
// - Clamp selects result, zero or 255.0
// - Span accumulator fills span, edge seeds it
// - Correction: span equals edge plus error times slope
// - Error is sign magnitude, bit 4 sign
// - Add or subtract slope/2../16 per bit
// - Slope scaling uses arithmetic right shift
// - One cycle per set error bit
// - Register messages write like synchronous memory
// - Register messages consumed, never forwarded
// - Mode bit 0 enable, bit 1 smooth
// - Hidden steps advance DDAs, emit no colour
// - Corrections applied only while enabled
// - Render setup loads both accumulators from start
// - Span step adds x slope; edge step reloads both
// - DDA updates only in smooth shading, except render setup
// - Other messages forwarded when queue has room
package cdda_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int TAG_W  = 9;
	localparam int DATA_W = 32;
	localparam int VAL_W  = 24;
	localparam int ACC_W  = 26;
	localparam int FRAC_W = 15;
	localparam int NCOMP  = 4;

	// ------------------------------------------------------------
	// Register update tags
	// ------------------------------------------------------------
	localparam logic [8:0] TAG_RED_START_VALUE   = 9'h000;
	localparam logic [8:0] TAG_RED_SLOPE_X       = 9'h001;
	localparam logic [8:0] TAG_RED_SLOPE_EDGE    = 9'h002;
	localparam logic [8:0] TAG_GREEN_START_VALUE = 9'h003;
	localparam logic [8:0] TAG_GREEN_SLOPE_X     = 9'h004;
	localparam logic [8:0] TAG_GREEN_SLOPE_EDGE  = 9'h005;
	localparam logic [8:0] TAG_BLUE_START_VALUE  = 9'h006;
	localparam logic [8:0] TAG_BLUE_SLOPE_X      = 9'h007;
	localparam logic [8:0] TAG_BLUE_SLOPE_EDGE   = 9'h008;
	localparam logic [8:0] TAG_ALPHA_START_VALUE = 9'h009;
	localparam logic [8:0] TAG_ALPHA_SLOPE_X     = 9'h00a;
	localparam logic [8:0] TAG_ALPHA_SLOPE_EDGE  = 9'h00b;
	localparam logic [8:0] TAG_FLAT_SHADE_VALUE  = 9'h00c;
	localparam logic [8:0] TAG_INTERP_MODE_CTRL  = 9'h00d;

	localparam logic [3:0][8:0] TAG_START = {TAG_ALPHA_START_VALUE,
		TAG_BLUE_START_VALUE, TAG_GREEN_START_VALUE, TAG_RED_START_VALUE};
	localparam logic [3:0][8:0] TAG_SLX = {TAG_ALPHA_SLOPE_X,
		TAG_BLUE_SLOPE_X, TAG_GREEN_SLOPE_X, TAG_RED_SLOPE_X};
	localparam logic [3:0][8:0] TAG_SLE = {TAG_ALPHA_SLOPE_EDGE,
		TAG_BLUE_SLOPE_EDGE, TAG_GREEN_SLOPE_EDGE, TAG_RED_SLOPE_EDGE};

	// ------------------------------------------------------------
	// Pipeline message tags
	// ------------------------------------------------------------
	localparam logic [8:0] TAG_RENDER_SETUP   = 9'h020;
	localparam logic [8:0] TAG_VIS_STEP_SPAN  = 9'h030;
	localparam logic [8:0] TAG_VIS_STEP_EDGE  = 9'h031;
	localparam logic [8:0] TAG_HID_STEP_SPAN  = 9'h032;
	localparam logic [8:0] TAG_HID_STEP_EDGE  = 9'h033;
	localparam logic [8:0] TAG_SUBPIXEL_FIX   = 9'h034;
	localparam logic [8:0] TAG_COLOUR         = 9'h040;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int MODE_ENABLE_BIT = 0;
	localparam int MODE_SMOOTH_BIT = 1;
	localparam int ERR_SIGN_BIT    = 4;
	localparam logic [1:0]  MODE_RESET = 2'h0;
	localparam logic [31:0] FLAT_RESET = 32'h0000_0000;
	localparam logic [25:0] CLAMP_MAX  = 26'h07f_8000;
	localparam logic [7:0]  BYTE_MAX   = 8'hff;

	typedef enum logic [1:0] {S_IDLE, S_PEND, S_CORR} cdda_fsm_t;

endpackage

// file: cdda_interp.sv
/*
 * Colour interpolator stage: four component DDAs with sub-pixel
 * correction, clamping and colour message generation.
 * Assumes in/out message ports are synchronous to sys_clk.
 */
`timescale 1ns/1ps
module cdda_interp (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        in_valid,
	output logic             in_ready,
	input  wire logic [8:0]  in_tag,
	input  wire logic [31:0] in_data,
	output logic             out_valid,
	input  wire logic        out_ready,
	output logic [8:0]       out_tag,
	output logic [31:0]      out_data
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		cdda_pkg::cdda_fsm_t fsm;
		logic [3:0][23:0]    start;
		logic [3:0][23:0]    slx;
		logic [3:0][23:0]    sle;
		logic [3:0][25:0]    span;
		logic [3:0][25:0]    edge_acc;
		logic [31:0]         flat;
		logic [1:0]          mode;
		logic [3:0]          err_bits;
		logic                err_neg;
		logic                corr_first;
		logic [8:0]          pend_tag;
		logic [31:0]         pend_data;
		logic                ovalid;
		logic [8:0]          otag;
		logic [31:0]         odata;
	} cdda_state_t;

	cdda_state_t st;
	cdda_state_t next_st;

	logic        slot_free;
	logic        take;
	logic        is_reg;
	logic        en;
	logic        smooth;
	logic        push;
	logic [31:0] colour;

	function automatic logic [25:0] cdda_sext(input logic [23:0] v);
		return {{2{v[23]}}, v};
	endfunction

	// Clamp to 0..255 and take the integer byte
	function automatic logic [7:0] cdda_clamp(input logic [25:0] a);
		if (a[25])
			return 8'h00;
		else if (a >= cdda_pkg::CLAMP_MAX)
			return cdda_pkg::BYTE_MAX;
		else
			return a[22:15];
	endfunction

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	assign slot_free = !st.ovalid || out_ready;
	assign in_ready  = (st.fsm == cdda_pkg::S_IDLE) && slot_free;
	assign take      = in_valid && in_ready;
	assign en        = st.mode[cdda_pkg::MODE_ENABLE_BIT];
	assign smooth    = st.mode[cdda_pkg::MODE_SMOOTH_BIT];
	assign is_reg    = (in_tag <= cdda_pkg::TAG_INTERP_MODE_CTRL);

	always_comb begin
		colour = '0;
		for (int c = 0; c < cdda_pkg::NCOMP; c++) begin
			colour[c*8 +: 8] = cdda_clamp(st.span[c]);
		end
		if (!smooth)
			colour = st.flat;
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [2:0]  sh;
		logic [25:0] part;
		logic [25:0] base;
		logic [3:0]  rest;
		int          k;
		sh      = '0;
		part    = '0;
		base    = '0;
		rest    = '0;
		k       = 0;
		next_st = st;
		push    = 1'b0;
		if (slot_free)
			next_st.ovalid = 1'b0;
		case (st.fsm)
			cdda_pkg::S_IDLE: begin
				if (take && is_reg) begin
					for (int c = 0; c < cdda_pkg::NCOMP; c++) begin
						if (in_tag == cdda_pkg::TAG_START[c])
							next_st.start[c] = in_data[23:0];
						if (in_tag == cdda_pkg::TAG_SLX[c])
							next_st.slx[c] = in_data[23:0];
						if (in_tag == cdda_pkg::TAG_SLE[c])
							next_st.sle[c] = in_data[23:0];
					end
					if (in_tag == cdda_pkg::TAG_FLAT_SHADE_VALUE)
						next_st.flat = in_data;
					if (in_tag == cdda_pkg::TAG_INTERP_MODE_CTRL)
						next_st.mode = in_data[1:0];
				end else if (take) begin
					// Forward by default
					push           = 1'b1;
					next_st.ovalid = 1'b1;
					next_st.otag   = in_tag;
					next_st.odata  = in_data;
					if (en) begin
						case (in_tag)
							cdda_pkg::TAG_RENDER_SETUP: begin
								for (int c = 0; c < cdda_pkg::NCOMP; c++) begin
									next_st.span[c]     = cdda_sext(st.start[c]);
									next_st.edge_acc[c] = cdda_sext(st.start[c]);
								end
							end
							cdda_pkg::TAG_VIS_STEP_SPAN,
							cdda_pkg::TAG_VIS_STEP_EDGE: begin
								next_st.otag      = cdda_pkg::TAG_COLOUR;
								next_st.odata     = colour;
								next_st.pend_tag  = in_tag;
								next_st.pend_data = in_data;
								next_st.fsm       = cdda_pkg::S_PEND;
							end
							cdda_pkg::TAG_SUBPIXEL_FIX: begin
								if (smooth) begin
									next_st.err_neg = in_data[cdda_pkg::ERR_SIGN_BIT];
									next_st.err_bits = in_data[3:0];
									if (in_data[3:0] != 4'h0) begin
										push              = 1'b0;
										next_st.ovalid    = 1'b0;
										next_st.pend_tag  = in_tag;
										next_st.pend_data = in_data;
										next_st.corr_first = 1'b1;
										next_st.fsm       = cdda_pkg::S_CORR;
									end else begin
										next_st.span = st.edge_acc;
									end
								end
							end
							default: begin
							end
						endcase
						// Step update after colour sampled
						if (smooth) begin
							for (int c = 0; c < cdda_pkg::NCOMP; c++) begin
								if (in_tag == cdda_pkg::TAG_VIS_STEP_SPAN ||
									in_tag == cdda_pkg::TAG_HID_STEP_SPAN)
									next_st.span[c] = st.span[c] +
										cdda_sext(st.slx[c]);
								if (in_tag == cdda_pkg::TAG_VIS_STEP_EDGE ||
									in_tag == cdda_pkg::TAG_HID_STEP_EDGE) begin
									next_st.edge_acc[c] = st.edge_acc[c] +
										cdda_sext(st.sle[c]);
									next_st.span[c] = st.edge_acc[c] +
										cdda_sext(st.sle[c]);
								end
							end
						end
					end
				end
			end
			cdda_pkg::S_PEND: begin
				if (slot_free) begin
					push           = 1'b1;
					next_st.ovalid = 1'b1;
					next_st.otag   = st.pend_tag;
					next_st.odata  = st.pend_data;
					next_st.fsm    = cdda_pkg::S_IDLE;
				end
			end
			cdda_pkg::S_CORR: begin
				// Highest set bit first, one per cycle
				for (int b = 0; b < 4; b++) begin
					if (st.err_bits[b])
						k = b;
				end
				sh   = 3'(4 - k);
				rest = st.err_bits;
				rest[k] = 1'b0;
				for (int c = 0; c < cdda_pkg::NCOMP; c++) begin
					base = st.corr_first ? st.edge_acc[c] : st.span[c];
					part = $signed(cdda_sext(st.slx[c])) >>> sh;
					if (st.err_neg)
						next_st.span[c] = base - part;
					else
						next_st.span[c] = base + part;
				end
				next_st.err_bits   = rest;
				next_st.corr_first = 1'b0;
				if (rest == 4'h0)
					next_st.fsm = cdda_pkg::S_PEND;
			end
			default: begin
				next_st.fsm = cdda_pkg::S_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign out_valid = st.ovalid;
	assign out_tag   = st.otag;
	assign out_data  = st.odata;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cdda_cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	logic vis_take;
	logic hid_take;
	logic [25:0] span0_step;
	assign vis_take = take && en && (in_tag == cdda_pkg::TAG_VIS_STEP_SPAN ||
		in_tag == cdda_pkg::TAG_VIS_STEP_EDGE);
	assign hid_take = take && en && (in_tag == cdda_pkg::TAG_HID_STEP_SPAN ||
		in_tag == cdda_pkg::TAG_HID_STEP_EDGE);
	assign span0_step = st.span[0] + cdda_sext(st.slx[0]);
	logic [25:0] half_slx0;
	logic [25:0] edge1_step;
	assign half_slx0  = {{3{st.slx[0][23]}}, st.slx[0][23:1]};
	assign edge1_step = st.edge_acc[1] + cdda_sext(st.sle[1]);

	a_reg_not_fwd: assert property (take && is_reg |-> !push
		##1 !out_valid)
		else $error("register message was forwarded");
	a_vis_colour_out: assert property (vis_take |=> out_valid &&
		out_tag == cdda_pkg::TAG_COLOUR ##0 st.fsm == cdda_pkg::S_PEND)
		else $error("visible step did not emit colour");
	a_flat_colour: assert property (vis_take && !smooth |=>
		out_data == $past(st.flat))
		else $error("flat colour not from constant value");
	a_hid_no_colour: assert property (hid_take |=>
		out_tag != cdda_pkg::TAG_COLOUR)
		else $error("hidden step emitted colour");
	a_corr_four_cycles: assert property (take && en && smooth &&
		in_tag == cdda_pkg::TAG_SUBPIXEL_FIX && in_data[3:0] == 4'hf |=>
		(st.fsm == cdda_pkg::S_CORR) [*4] ##1 st.fsm == cdda_pkg::S_PEND)
		else $error("correction cycle count wrong");
	a_flat_dda_hold: assert property (take && !smooth &&
		in_tag != cdda_pkg::TAG_RENDER_SETUP && !is_reg |=>
		$stable(st.span) && $stable(st.edge_acc))
		else $error("DDA moved in flat shading");
	a_render_load: assert property (take && en &&
		in_tag == cdda_pkg::TAG_RENDER_SETUP |=>
		st.span[0] == cdda_sext($past(st.start[0])) &&
		st.edge_acc[3] == cdda_sext($past(st.start[3])))
		else $error("render setup did not load accumulators");
	a_span_step_add: assert property (take && en && smooth &&
		in_tag == cdda_pkg::TAG_HID_STEP_SPAN |=>
		st.span[0] == $past(span0_step) && $stable(st.edge_acc))
		else $error("span step wrong");
	a_disabled_fwd: assert property (take && !en && !is_reg |=>
		out_valid && out_tag == $past(in_tag) && out_data == $past(in_data))
		else $error("disabled stage did not forward");
	a_stall_full: assert property (out_valid && !out_ready |->
		!in_ready ##1 out_valid)
		else $error("input taken or output dropped under stall");

	// ------------------------------------------------------------
	// Correction checks
	// ------------------------------------------------------------
	a_corr_pos_half: assert property (take && en && smooth &&
		in_tag == cdda_pkg::TAG_SUBPIXEL_FIX && in_data[4:0] == 5'h08 |=>
		##1 st.span[0] ==
		$past(st.edge_acc[0], 2) + $past(half_slx0, 2))
		else $error("positive half correction wrong");
	a_corr_neg_half: assert property (take && en && smooth &&
		in_tag == cdda_pkg::TAG_SUBPIXEL_FIX && in_data[4:0] == 5'h18 |=>
		##1 st.span[0] ==
		$past(st.edge_acc[0], 2) - $past(half_slx0, 2))
		else $error("negative half correction wrong");
	a_corr_zero_err: assert property (take && en && smooth &&
		in_tag == cdda_pkg::TAG_SUBPIXEL_FIX && in_data[3:0] == 4'h0 |=>
		st.span == $past(st.edge_acc) && out_valid)
		else $error("zero correction did not copy edge");
	a_corr_fwd_late: assert property (take && en && smooth &&
		in_tag == cdda_pkg::TAG_SUBPIXEL_FIX && in_data[3:0] == 4'hf |=>
		##5 out_valid && out_tag == cdda_pkg::TAG_SUBPIXEL_FIX)
		else $error("correction message not forwarded");
	a_corr_disabled: assert property (take && !en &&
		in_tag == cdda_pkg::TAG_SUBPIXEL_FIX |=>
		st.fsm == cdda_pkg::S_IDLE && $stable(st.span))
		else $error("correction applied while disabled");
	a_corr_edge_hold: assert property (st.fsm == cdda_pkg::S_CORR |=>
		$stable(st.edge_acc))
		else $error("edge accumulator moved in correction");
	a_busy_block: assert property (st.fsm != cdda_pkg::S_IDLE |->
		!in_ready)
		else $error("input taken while busy");

	// ------------------------------------------------------------
	// Clamp and colour checks
	// ------------------------------------------------------------
	a_clamp_top: assert property (smooth && !st.span[0][25] &&
		st.span[0] >= cdda_pkg::CLAMP_MAX |-> colour[7:0] == 8'hff)
		else $error("clamp to 255 failed");
	a_clamp_floor: assert property (smooth && st.span[2][25] |->
		colour[23:16] == 8'h00)
		else $error("clamp to zero failed");
	a_clamp_pass: assert property (smooth && !st.span[1][25] &&
		st.span[1] < cdda_pkg::CLAMP_MAX |-> colour[15:8] == st.span[1][22:15])
		else $error("unclamped byte wrong");
	a_alpha_floor: assert property (smooth && st.span[3][25] |->
		colour[31:24] == 8'h00)
		else $error("alpha not computed");
	a_flat_const: assert property (!smooth |-> colour == st.flat)
		else $error("flat colour not constant value");
	a_vis_then_fwd: assert property (vis_take ##1 out_ready |=>
		out_valid && out_tag == $past(in_tag, 2) &&
		out_data == $past(in_data, 2))
		else $error("step not forwarded after colour");

	// ------------------------------------------------------------
	// Register and handshake checks
	// ------------------------------------------------------------
	a_slope_write: assert property (take &&
		in_tag == cdda_pkg::TAG_RED_SLOPE_X |=>
		st.slx[0] == $past(in_data[23:0]))
		else $error("slope register not written");
	a_start_write: assert property (take &&
		in_tag == cdda_pkg::TAG_ALPHA_START_VALUE |=>
		st.start[3] == $past(in_data[23:0]))
		else $error("start register not written");
	a_flat_write: assert property (take &&
		in_tag == cdda_pkg::TAG_FLAT_SHADE_VALUE |=>
		st.flat == $past(in_data))
		else $error("constant value not written");
	a_mode_write: assert property (take &&
		in_tag == cdda_pkg::TAG_INTERP_MODE_CTRL |=>
		st.mode == $past(in_data[1:0]))
		else $error("mode register not written");
	a_reg_acc_hold: assert property (take && is_reg |=>
		$stable(st.span) && $stable(st.edge_acc))
		else $error("register message moved accumulators");
	a_edge_step: assert property (take && en && smooth &&
		in_tag == cdda_pkg::TAG_HID_STEP_EDGE |=>
		st.edge_acc[1] == $past(edge1_step) &&
		st.span[1] == st.edge_acc[1])
		else $error("edge step wrong");
	a_out_hold: assert property (out_valid && !out_ready |=>
		$stable(out_tag) && $stable(out_data))
		else $error("output changed under stall");

	c_vis_smooth: cover property (vis_take && smooth);
	c_vis_flat: cover property (vis_take && !smooth);
	c_corr_done: cover property (st.fsm == cdda_pkg::S_CORR ##1
		st.fsm == cdda_pkg::S_PEND);
	c_reg_write: cover property (take && is_reg);
	c_corr_neg: cover property (st.fsm == cdda_pkg::S_CORR && st.err_neg);

endmodule

// file: cdda_sink.sv
/*
 * Downstream pipeline model for the colour interpolator stage.
 * Assumes the stage holds its output message until it is taken.
 */
`timescale 1ns/1ps
module cdda_sink (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic slow,
	output logic      out_ready
);
	logic [1:0] stall_cnt;

	// ------------------------------------------------------------
	// Queue room: three cycles full in four when slow
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			stall_cnt <= 2'h0;
		else
			stall_cnt <= stall_cnt + 2'h1;
	end

	assign out_ready = !slow || (stall_cnt == 2'h0);
endmodule

// file: tb.sv
/*
 * Self-checking bench for the colour interpolator stage.
 * Assumes cdda_pkg, cdda_interp and cdda_sink are compiled first.
 */
`timescale 1ns/1ps
module tb;
	logic        sys_clk;
	logic        rst_n;
	logic        in_valid;
	logic        in_ready;
	logic [8:0]  in_tag;
	logic [31:0] in_data;
	logic        out_valid;
	logic        out_ready;
	logic [8:0]  out_tag;
	logic [31:0] out_data;
	logic        slow;
	logic [40:0] exp_q [$];
	logic [15:0] lf;
	logic [1:0]  md;
	logic [31:0] fl;
	int          sp [4];
	int          ed [4];
	int          st [4];
	int          sx [4];
	int          se [4];
	int          n_fail;
	int          checks_done;
	logic [8:0]  mtag [6] = '{9'h030, 9'h031, 9'h032, 9'h033, 9'h034,
		9'h100};
	logic [3:0]  mag [3] = '{4'hf, 4'h8, 4'h0};

	cdda_interp dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.in_valid(in_valid), .in_ready(in_ready), .in_tag(in_tag),
		.in_data(in_data), .out_valid(out_valid), .out_ready(out_ready),
		.out_tag(out_tag), .out_data(out_data));
	cdda_sink sink (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow),
		.out_ready(out_ready));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ------------------------------------------------------------
	// Reference arithmetic
	// ------------------------------------------------------------
	function logic [15:0] lfsr();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf;
	endfunction

	function int wr(input int a);
		return (a <<< 6) >>> 6;
	endfunction

	function logic [7:0] cl(input int a);
		if (a < 0)
			return 8'h00;
		if (a >= 32'h007f_8000)
			return 8'hff;
		return 8'(a >>> 15);
	endfunction

	function logic [31:0] colour();
		logic [31:0] c;
		c = fl;
		if (md[1])
			for (int i = 0; i < 4; i++)
				c[8*i +: 8] = cl(sp[i]);
		return c;
	endfunction

	task model(input logic [8:0] t, input logic [31:0] d);
		int c;
		int k;
		c = int'(t) / 3;
		k = int'(t) % 3;
		if (t <= 9'h00d) begin
			if (t == cdda_pkg::TAG_FLAT_SHADE_VALUE)
				fl = d;
			else if (t == cdda_pkg::TAG_INTERP_MODE_CTRL)
				md = d[1:0];
			else if (k == 0)
				st[c] = int'($signed(d[23:0]));
			else if (k == 1)
				sx[c] = int'($signed(d[23:0]));
			else
				se[c] = int'($signed(d[23:0]));
			return;
		end
		if (md[0]) begin
			if (t == 9'h030 || t == 9'h031)
				exp_q.push_back({cdda_pkg::TAG_COLOUR, colour()});
			for (int i = 0; i < 4; i++) begin
				if (t == cdda_pkg::TAG_RENDER_SETUP) begin
					sp[i] = st[i];
					ed[i] = st[i];
				end
				if (md[1] && (t == 9'h030 || t == 9'h032))
					sp[i] = wr(sp[i] + sx[i]);
				if (md[1] && (t == 9'h031 || t == 9'h033)) begin
					ed[i] = wr(ed[i] + se[i]);
					sp[i] = ed[i];
				end
				if (md[1] && t == cdda_pkg::TAG_SUBPIXEL_FIX) begin
					sp[i] = ed[i];
					for (int b = 3; b >= 0; b--)
						if (d[b])
							sp[i] = wr(d[4] ? sp[i] - (sx[i] >>> (4 - b)) :
								sp[i] + (sx[i] >>> (4 - b)));
				end
			end
		end
		exp_q.push_back({t, d});
	endtask

	// ------------------------------------------------------------
	// Driver, monitor and verdict
	// ------------------------------------------------------------
	task complete_run();
		$display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task put(input logic [8:0] t, input logic [31:0] d);
		int k;
		in_valid <= 1'b1;
		in_tag   <= t;
		in_data  <= d;
		@(negedge sys_clk);
		for (k = 0; k < 200 && in_ready !== 1'b1; k++)
			@(negedge sys_clk);
		if (k == 200) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, in_ready, 1'b1);
			complete_run();
		end else begin
			@(posedge sys_clk);
			model(t, d);
		end
	endtask

	always @(negedge sys_clk) begin
		if (rst_n === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1) begin
			checks_done++;
			if (exp_q.size() == 0 || {out_tag, out_data} !== exp_q[0]) begin
				n_fail++;
				$display("CHECK FAILED t=%0t got %h exp %h", $time,
					{out_tag, out_data}, exp_q.size() ? exp_q[0] : 41'h0);
			end
			if (exp_q.size() > 0)
				void'(exp_q.pop_front());
		end
	end

	initial begin
		int k;
		rst_n    = 1'b0;
		in_valid = 1'b0;
		in_tag   = 9'h000;
		in_data  = 32'h0000_0000;
		slow     = 1'b0;
		lf       = 16'hb750;
		md       = 2'h0;
		fl       = 32'h0000_0000;
		n_fail   = 0;
		checks_done = 0;
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		put(cdda_pkg::TAG_VIS_STEP_SPAN, 32'h0000_0001);
		for (int m = 0; m < 8; m++) begin
			slow <= m[0];
			put(cdda_pkg::TAG_INTERP_MODE_CTRL, {30'h0, m[2:1]});
			for (int r = 0; r < 13; r++)
				put(9'(r), {lfsr(), lfsr()});
			if (m >= 6) begin
				put(cdda_pkg::TAG_RED_START_VALUE, 32'h007f_8000);
				put(cdda_pkg::TAG_GREEN_START_VALUE, 32'h007f_7fff);
				put(cdda_pkg::TAG_BLUE_START_VALUE, 32'h0080_0000);
			end
			if (!m[1])
				put(cdda_pkg::TAG_COLOUR, {lfsr(), lfsr()});
			put(cdda_pkg::TAG_RENDER_SETUP, 32'h0000_0000);
			for (k = 0; k < 3; k++)
				put(cdda_pkg::TAG_SUBPIXEL_FIX, {27'h0, m[0], mag[k]});
			for (k = 0; k < 16; k++)
				put(mtag[lfsr() % 6], {lfsr(), lfsr()});
			put(cdda_pkg::TAG_INTERP_MODE_CTRL, 32'h0000_0003);
			put(cdda_pkg::TAG_VIS_STEP_SPAN, 32'h0000_0002);
		end
		in_valid <= 1'b0;
		for (k = 0; k < 500 && exp_q.size() > 0; k++)
			@(posedge sys_clk);
		if (exp_q.size() > 0) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time,
				exp_q.size(), 0);
		end
		complete_run();
	end
endmodule
